// ===== dcd_pkg.sv
// Purpose: Shared constants and types for the signal processor core datapath.
// Assumes: 16-bit data words, 32-bit accumulator, single machine clock.
// Notes: Operation codes are internal encodings of this datapath.
package dcd_pkg;
  localparam int W = 16;
  localparam int AW = 32;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int PAGE_W = 9;
  localparam int OFS_W = 7;
  localparam logic [AW-1:0] ACC_MAX = 32'h7FFFFFFF;
  localparam logic [AW-1:0] ACC_MIN = 32'h80000000;
  localparam logic [W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] CBC_RESET = 8'h00;
  localparam int CBC_EN1 = 3;
  localparam int CBC_EN2 = 7;
  localparam logic [4:0] SHIFT_MAX = 5'h10;
  localparam logic [2:0] POST_MAX = 3'h7;

  // Arithmetic unit operations
  typedef enum logic [2:0] {
    DCD_ALU_NOP = 3'b000,
    DCD_ALU_LOAD = 3'b001,
    DCD_ALU_ADD = 3'b010,
    DCD_ALU_SUB = 3'b011,
    DCD_ALU_AND = 3'b100,
    DCD_ALU_OR = 3'b101,
    DCD_ALU_XOR = 3'b110,
    DCD_ALU_SHR = 3'b111
  } dcd_alu_op_t;

  // Arithmetic unit operand source
  typedef enum logic [1:0] {
    DCD_SRC_DATA = 2'b00,
    DCD_SRC_IMM = 2'b01,
    DCD_SRC_PROD = 2'b10,
    DCD_SRC_BUF = 2'b11
  } dcd_src_t;

  // Second multiplier operand source
  typedef enum logic [1:0] {
    DCD_MSRC_DATA = 2'b00,
    DCD_MSRC_IMM = 2'b01,
    DCD_MSRC_PROG = 2'b10,
    DCD_MSRC_NONE = 2'b11
  } dcd_msrc_t;

  // Logic unit operations
  typedef enum logic [1:0] {
    DCD_PLU_AND = 2'b00,
    DCD_PLU_OR = 2'b01,
    DCD_PLU_XOR = 2'b10,
    DCD_PLU_PASS = 2'b11
  } dcd_plu_op_t;

  // Program sequencing requests
  typedef enum logic [1:0] {
    DCD_SEQ_STEP = 2'b00,
    DCD_SEQ_CALL = 2'b01,
    DCD_SEQ_RET = 2'b10,
    DCD_SEQ_INT = 2'b11
  } dcd_seq_t;
endpackage

// ===== dcd_shifter.sv
// Purpose: Input scaling shifter, 16-bit word to 32-bit operand.
// Assumes: Shift count already limited to 0..16 by caller.
// Notes: Purely combinational.
`timescale 1ns/1ps
module dcd_shifter import dcd_pkg::*; (
  input wire logic [W-1:0] din,
  input wire logic [4:0] count,
  input wire logic sign_ext,
  output logic [AW-1:0] dout
);
  logic [AW-1:0] ext;
  // Upper bits by sign mode, low bits zero filled
  always_comb begin
    ext = sign_ext ? {{W{din[W-1]}}, din} : {{W{1'b0}}, din};
    dout = ext << count;
  end
endmodule // dcd_shifter

// ===== dcd_multiplier.sv
// Purpose: Signed 16x16 multiplier array.
// Assumes: Both operands twos complement.
// Notes: Combinational; result captured by the caller in one cycle.
`timescale 1ns/1ps
module dcd_multiplier import dcd_pkg::*; (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [AW-1:0] p
);
  // Full-width signed product
  always_comb begin
    // Operands widened first so the product never wraps at 16 bits
    p = AW'($signed({{W{a[W-1]}}, a}) * $signed({{W{b[W-1]}}, b}));
  end
endmodule // dcd_multiplier

// ===== dcd_core.sv
// Purpose: Arithmetic, logic, multiply and sequencing datapath of a 16-bit DSP core.
// Assumes: Decode logic outside drives one-cycle control strobes per instruction.
// Notes: Memory writes are registered outputs; status bits are plain ports.
`timescale 1ns/1ps
// Function
// - 32-bit twos-complement arithmetic and Boolean unit
// - Accumulator feeds back, high/low words storable
// - 32-bit accumulator buffer saves and restores
// - Logic unit edits memory, leaves accumulator
// - Signed 16x16 multiply, 32-bit single cycle
// - Multiplicand register and readable product halves
// - Multiplier operand from data, immediate, program
// - Input shifter left 0 to 16
// - Zero low fill, sign mode upper fill
// - Right shift accumulator; output shift 0-7
// - Eight-entry stack for calls and interrupts
// - Interrupt shadows context, return restores it
// - Block repeat reloads start at end address
// - Block repeat counter and start address
// - Direct address is page plus offset
// - Circular buffer control, starts and ends
// - Prefetch counter tracks prefetch and transfers
// - Program counter updates after every decode
// - Prescale count from shift or bit pointer
// - Carry, overflow flag and saturate mode
// - Dual RAM space select and overlay bit
// - Bus request for global region accesses
module dcd_core import dcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic alu_en,
  input wire dcd_alu_op_t alu_op,
  input wire dcd_src_t alu_src,
  input wire logic [W-1:0] data_in,
  input wire logic [W-1:0] imm_in,
  input wire logic [W-1:0] prog_in,
  input wire logic shift_use_reg,
  input wire logic [4:0] shift_imm,
  input wire logic [2:0] post_shift,
  input wire logic acc_to_buf,
  input wire logic buf_to_acc,
  input wire logic plu_en,
  input wire dcd_plu_op_t plu_op,
  input wire logic plu_use_mask,
  input wire logic mpy_en,
  input wire dcd_msrc_t mpy_src,
  input wire logic multiplicand_load,
  input wire logic shift_count_load,
  input wire logic bit_pointer_load,
  input wire logic mask_load,
  input wire logic count_load_shift,
  input wire logic count_load_bit,
  input wire logic count_from_reg,
  input wire logic [3:0] count_imm,
  input wire logic sign_extend_mode_flag,
  input wire logic overflow_saturate_mode,
  input wire logic dual_ram_space_select,
  input wire logic single_ram_overlay_bit,
  input wire logic [W-1:0] aux_index_in,
  input wire logic [W-1:0] aux_compare_in,
  input wire logic [W-1:0] mode_in,
  input wire logic decode,
  input wire dcd_seq_t seq_op,
  input wire logic [W-1:0] branch_addr,
  input wire logic prefetch,
  input wire logic pfc_load,
  input wire logic [W-1:0] pfc_addr,
  input wire logic block_repeat_start,
  input wire logic [W-1:0] block_start_in,
  input wire logic [W-1:0] block_end_in,
  input wire logic [W-1:0] block_count_in,
  input wire logic page_load,
  input wire logic [PAGE_W-1:0] page_in,
  input wire logic [OFS_W-1:0] dir_offset,
  input wire logic dir_access,
  input wire logic [7:0] global_region_reg,
  input wire logic circ_load,
  input wire logic [7:0] circ_ctrl_in,
  input wire logic [W-1:0] circ_start_one_in,
  input wire logic [W-1:0] circ_end_one_in,
  input wire logic [W-1:0] circ_start_two_in,
  input wire logic [W-1:0] circ_end_two_in,
  output logic [AW-1:0] acc_r,
  output logic [AW-1:0] accumulator_buffer_r,
  output logic [W-1:0] acc_high_store_r,
  output logic [W-1:0] acc_low_store_r,
  output logic [AW-1:0] product_reg_r,
  output logic [W-1:0] multiplicand_reg_r,
  output logic [W-1:0] dynamic_shift_count_reg_r,
  output logic [W-1:0] dynamic_bit_pointer_reg_r,
  output logic [W-1:0] bit_manip_mask_reg_r,
  output logic [3:0] prescale_count_r,
  output logic [W-1:0] plu_wdata_r,
  output logic plu_we_r,
  output logic carry_r,
  output logic overflow_flag_r,
  output logic [W-1:0] pc_r,
  output logic [W-1:0] prefetch_counter_r,
  output logic [PTR_W:0] stack_level_r,
  output logic block_repeat_active_flag_r,
  output logic [W-1:0] block_repeat_counter_r,
  output logic [W-1:0] block_start_addr_reg_r,
  output logic [W-1:0] block_end_addr_reg_r,
  output logic [W-1:0] data_addr_r,
  output logic [PAGE_W-1:0] data_page_pointer_r,
  output logic global_bus_request_r,
  output logic [7:0] circ_buffer_control_r,
  output logic [W-1:0] circ_start_one_r,
  output logic [W-1:0] circ_end_one_r,
  output logic [W-1:0] circ_start_two_r,
  output logic [W-1:0] circ_end_two_r,
  output logic dual_ram_space_select_r,
  output logic single_ram_overlay_bit_r,
  output logic [W-1:0] aux_index_reg_r,
  output logic [W-1:0] aux_compare_reg_r,
  output logic [W-1:0] processor_mode_reg_r
);
  logic [AW-1:0] shifted, product, operand, acc_nxt, acc_post;
  logic [AW:0] sum;
  logic ovf, carry_nxt;
  logic [4:0] shift_cnt;
  logic [W-1:0] mpy_b, plu_opnd;
  logic [W-1:0] stack_mem [STACK_DEPTH];
  logic [PTR_W-1:0] sp_idx;
  logic [W-1:0] pc_nxt;
  // One-deep interrupt shadow
  logic [AW-1:0] sh_acc, sh_buf, sh_prod;
  logic [W-1:0] sh_mcand, sh_shc, sh_bitp, sh_idx, sh_cmp, sh_mode;
  logic sh_carry, sh_ovf, sh_dual, sh_single_ram_overlay_bit;

  // Clamp a shift count to the 0..16 range
  function automatic logic [4:0] clamp16(input logic [W-1:0] c);
    return (c > W'(SHIFT_MAX)) ? SHIFT_MAX : 5'(c);
  endfunction

  // Input shift count: full register word is clamped, not truncated first
  assign shift_cnt = clamp16(shift_use_reg ? dynamic_shift_count_reg_r : W'(shift_imm));

  dcd_shifter u_shifter (
    .din(alu_src == DCD_SRC_IMM ? imm_in : data_in),
    .count(shift_cnt),
    .sign_ext(sign_extend_mode_flag),
    .dout(shifted)
  );

  // Second multiplier operand select
  always_comb begin
    case (mpy_src)
      DCD_MSRC_DATA: mpy_b = data_in;
      DCD_MSRC_IMM: mpy_b = imm_in;
      DCD_MSRC_PROG: mpy_b = prog_in;
      default: mpy_b = data_in;
    endcase
  end

  dcd_multiplier u_mpy (
    .a(multiplicand_reg_r),
    .b(mpy_b),
    .p(product)
  );

  // Arithmetic unit with wrap or saturate
  always_comb begin
    operand = shifted;
    if (alu_src == DCD_SRC_PROD) begin
      operand = product_reg_r;
    end else if (alu_src == DCD_SRC_BUF) begin
      operand = accumulator_buffer_r;
    end
    sum = {1'b0, acc_r};
    ovf = 1'b0;
    case (alu_op)
      DCD_ALU_LOAD: sum = {1'b0, operand};
      DCD_ALU_ADD: begin
        sum = {1'b0, acc_r} + {1'b0, operand};
        ovf = (acc_r[AW-1] == operand[AW-1]) && (sum[AW-1] != acc_r[AW-1]);
      end
      DCD_ALU_SUB: begin
        sum = {1'b0, acc_r} - {1'b0, operand};
        sum[AW] = ~sum[AW]; // Carry means no borrow
        ovf = (acc_r[AW-1] != operand[AW-1]) && (sum[AW-1] != acc_r[AW-1]);
      end
      DCD_ALU_AND: sum = {1'b0, acc_r & operand};
      DCD_ALU_OR: sum = {1'b0, acc_r | operand};
      DCD_ALU_XOR: sum = {1'b0, acc_r ^ operand};
      DCD_ALU_SHR: sum = {1'b0, AW'($signed(acc_r) >>> shift_cnt)};
      default: sum = {1'b0, acc_r};
    endcase
    carry_nxt = (alu_op == DCD_ALU_ADD || alu_op == DCD_ALU_SUB) ? sum[AW] : carry_r;
    acc_nxt = sum[AW-1:0];
    if (ovf && overflow_saturate_mode) begin
      acc_nxt = acc_r[AW-1] ? ACC_MIN : ACC_MAX;
    end
    acc_post = acc_r << ((post_shift > POST_MAX) ? POST_MAX : post_shift);
  end

  // Accumulator, buffer and flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= '0;
      accumulator_buffer_r <= '0;
      carry_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end else if (seq_op == DCD_SEQ_RET && decode) begin
      acc_r <= sh_acc;
      accumulator_buffer_r <= sh_buf;
      carry_r <= sh_carry;
      overflow_flag_r <= sh_ovf;
    end else begin
      if (alu_en && alu_op != DCD_ALU_NOP) begin
        acc_r <= acc_nxt;
        carry_r <= carry_nxt;
        if (ovf) begin
          overflow_flag_r <= 1'b1;
        end
      end else if (buf_to_acc) begin
        acc_r <= accumulator_buffer_r;
      end
      if (acc_to_buf) begin
        accumulator_buffer_r <= acc_r;
      end
    end
  end

  // Stored accumulator words after the output shifter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_high_store_r <= '0;
      acc_low_store_r <= '0;
    end else begin
      acc_high_store_r <= acc_post[AW-1:W];
      acc_low_store_r <= acc_post[W-1:0];
    end
  end

  // Multiplier registers and temporaries
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      product_reg_r <= '0;
      multiplicand_reg_r <= '0;
      dynamic_shift_count_reg_r <= '0;
      dynamic_bit_pointer_reg_r <= '0;
      bit_manip_mask_reg_r <= '0;
    end else if (seq_op == DCD_SEQ_RET && decode) begin
      product_reg_r <= sh_prod;
      multiplicand_reg_r <= sh_mcand;
      dynamic_shift_count_reg_r <= sh_shc;
      dynamic_bit_pointer_reg_r <= sh_bitp;
    end else begin
      if (mpy_en) begin
        product_reg_r <= product;
      end
      if (multiplicand_load) begin
        multiplicand_reg_r <= data_in;
      end
      if (shift_count_load) begin
        dynamic_shift_count_reg_r <= data_in;
      end
      if (bit_pointer_load) begin
        dynamic_bit_pointer_reg_r <= data_in;
      end
      if (mask_load) begin
        bit_manip_mask_reg_r <= data_in;
      end
    end
  end

  // Prescale count register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale_count_r <= '0;
    end else if (count_load_shift) begin
      prescale_count_r <= count_from_reg ? dynamic_shift_count_reg_r[3:0] : count_imm;
    end else if (count_load_bit) begin
      prescale_count_r <= count_from_reg ? dynamic_bit_pointer_reg_r[3:0] : count_imm;
    end
  end

  // Logic unit writes memory directly
  assign plu_opnd = plu_use_mask ? bit_manip_mask_reg_r : imm_in;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      plu_wdata_r <= '0;
      plu_we_r <= 1'b0;
    end else begin
      plu_we_r <= plu_en;
      case (plu_op)
        DCD_PLU_AND: plu_wdata_r <= data_in & plu_opnd;
        DCD_PLU_OR: plu_wdata_r <= data_in | plu_opnd;
        DCD_PLU_XOR: plu_wdata_r <= data_in ^ plu_opnd;
        default: plu_wdata_r <= plu_opnd;
      endcase
    end
  end

  // Next program counter with block repeat compare
  assign sp_idx = PTR_W'(stack_level_r - 1'b1);
  always_comb begin
    pc_nxt = pc_r + 1'b1;
    case (seq_op)
      DCD_SEQ_CALL, DCD_SEQ_INT: pc_nxt = branch_addr;
      DCD_SEQ_RET: pc_nxt = stack_mem[sp_idx];
      default: begin
        if (block_repeat_active_flag_r && pc_r == block_end_addr_reg_r) begin
          pc_nxt = block_start_addr_reg_r;
        end
      end
    endcase
  end

  // Program counter and stack
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_r <= PC_RESET;
      stack_level_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_mem[i] <= '0;
      end
    end else if (decode) begin
      pc_r <= pc_nxt;
      if ((seq_op == DCD_SEQ_CALL || seq_op == DCD_SEQ_INT) && stack_level_r != (PTR_W+1)'(STACK_DEPTH)) begin
        stack_mem[stack_level_r[PTR_W-1:0]] <= pc_r + 1'b1;
        stack_level_r <= stack_level_r + 1'b1;
      end else if (seq_op == DCD_SEQ_RET && stack_level_r != '0) begin
        stack_level_r <= stack_level_r - 1'b1;
      end
    end
  end

  // Block repeat registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      block_repeat_active_flag_r <= 1'b0;
      block_repeat_counter_r <= '0;
      block_start_addr_reg_r <= '0;
      block_end_addr_reg_r <= '0;
    end else if (block_repeat_start) begin
      block_repeat_active_flag_r <= 1'b1;
      block_repeat_counter_r <= block_count_in;
      block_start_addr_reg_r <= block_start_in;
      block_end_addr_reg_r <= block_end_in;
    end else if (decode && seq_op == DCD_SEQ_STEP && block_repeat_active_flag_r
                 && pc_r == block_end_addr_reg_r) begin
      if (block_repeat_counter_r == '0) begin
        block_repeat_active_flag_r <= 1'b0;
      end else begin
        block_repeat_counter_r <= block_repeat_counter_r - 1'b1;
      end
    end
  end

  // Prefetch counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prefetch_counter_r <= PC_RESET;
    end else if (pfc_load) begin
      prefetch_counter_r <= pfc_addr;
    end else if (prefetch) begin
      prefetch_counter_r <= prefetch_counter_r + 1'b1;
    end
  end

  // Direct address and global bus request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_page_pointer_r <= '0;
      data_addr_r <= '0;
      global_bus_request_r <= 1'b0;
    end else begin
      if (page_load) begin
        data_page_pointer_r <= page_in;
      end
      data_addr_r <= {data_page_pointer_r, dir_offset};
      global_bus_request_r <= dir_access && global_region_reg != 8'h00
        && ((data_page_pointer_r[PAGE_W-1:1] & global_region_reg) == global_region_reg);
    end
  end

  // Circular buffer and configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      circ_buffer_control_r <= CBC_RESET;
      circ_start_one_r <= '0;
      circ_end_one_r <= '0;
      circ_start_two_r <= '0;
      circ_end_two_r <= '0;
    end else if (circ_load) begin
      circ_buffer_control_r <= circ_ctrl_in;
      circ_start_one_r <= circ_start_one_in;
      circ_end_one_r <= circ_end_one_in;
      circ_start_two_r <= circ_start_two_in;
      circ_end_two_r <= circ_end_two_in;
    end
  end

  // Mode and index registers, restored on return
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dual_ram_space_select_r <= 1'b0;
      single_ram_overlay_bit_r <= 1'b0;
      aux_index_reg_r <= '0;
      aux_compare_reg_r <= '0;
      processor_mode_reg_r <= '0;
    end else if (seq_op == DCD_SEQ_RET && decode) begin
      dual_ram_space_select_r <= sh_dual;
      single_ram_overlay_bit_r <= sh_single_ram_overlay_bit;
      aux_index_reg_r <= sh_idx;
      aux_compare_reg_r <= sh_cmp;
      processor_mode_reg_r <= sh_mode;
    end else begin
      dual_ram_space_select_r <= dual_ram_space_select;
      single_ram_overlay_bit_r <= single_ram_overlay_bit;
      aux_index_reg_r <= aux_index_in;
      aux_compare_reg_r <= aux_compare_in;
      processor_mode_reg_r <= mode_in;
    end
  end

  // Interrupt context shadow capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {sh_acc, sh_buf, sh_prod} <= '0;
      {sh_mcand, sh_shc, sh_bitp, sh_idx, sh_cmp, sh_mode} <= '0;
      {sh_carry, sh_ovf, sh_dual, sh_single_ram_overlay_bit} <= '0;
    end else if (decode && seq_op == DCD_SEQ_INT) begin
      sh_acc <= acc_r;
      sh_buf <= accumulator_buffer_r;
      sh_prod <= product_reg_r;
      sh_mcand <= multiplicand_reg_r;
      sh_shc <= dynamic_shift_count_reg_r;
      sh_bitp <= dynamic_bit_pointer_reg_r;
      sh_idx <= aux_index_reg_r;
      sh_cmp <= aux_compare_reg_r;
      sh_mode <= processor_mode_reg_r;
      {sh_carry, sh_ovf, sh_dual, sh_single_ram_overlay_bit} <= {carry_r, overflow_flag_r, dual_ram_space_select_r,
                                               single_ram_overlay_bit_r};
    end
  end

  // Product follows the multiplier one cycle after a multiply
  mpy_product_a: assert property (@(posedge clk) disable iff (reset)
    mpy_en && !(seq_op == DCD_SEQ_RET && decode) |=> product_reg_r == $past(product)) else $error("product wrong");
  sat_pos_a: assert property (@(posedge clk) disable iff (reset)
    alu_en && alu_op == DCD_ALU_ADD && ovf && overflow_saturate_mode && !acc_r[AW-1]
    && !(seq_op == DCD_SEQ_RET && decode) |=> acc_r == ACC_MAX) else $error("no saturation");
  repeat_jump_a: assert property (@(posedge clk) disable iff (reset)
    decode && seq_op == DCD_SEQ_STEP && block_repeat_active_flag_r && pc_r == block_end_addr_reg_r
    |=> pc_r == $past(block_start_addr_reg_r)) else $error("repeat jump missing");
  stack_bound_a: assert property (@(posedge clk) disable iff (reset)
    stack_level_r <= (PTR_W+1)'(STACK_DEPTH)) else $error("stack overrun");
  page_addr_a: assert property (@(posedge clk) disable iff (reset)
    ##1 data_addr_r == {$past(data_page_pointer_r), $past(dir_offset)}) else $error("bad address");
  plu_keep_acc_a: assert property (@(posedge clk) disable iff (reset)
    plu_en && !alu_en && !buf_to_acc && !decode |=> $stable(acc_r)) else $error("logic unit hit acc");
  ovf_flag_a: assert property (@(posedge clk) disable iff (reset)
    alu_en && ovf && alu_op != DCD_ALU_NOP && !(seq_op == DCD_SEQ_RET && decode)
    |=> overflow_flag_r) else $error("overflow not flagged");
  buf_copy_a: assert property (@(posedge clk) disable iff (reset)
    acc_to_buf && !(seq_op == DCD_SEQ_RET && decode) |=> accumulator_buffer_r == $past(acc_r)) else $error("buffer copy");
endmodule // dcd_core

// ===== dcd_mem_model.sv
// Purpose: Program and data memory seen by the datapath across its two buses.
// Assumes: Data writes come from the logic unit write strobe at the data address.
// Notes: Program words are a fixed pattern of the address, so no load is needed.
`timescale 1ns/1ps
module dcd_mem_model (
  input wire logic clk,
  input wire logic [15:0] data_addr,
  input wire logic we,
  input wire logic [15:0] wdata,
  input wire logic [15:0] prog_addr,
  output logic [15:0] prog_rdata
);
  logic [15:0] dmem [0:65535];
  // Program word read at the prefetch address, value derived from the address
  assign prog_rdata = prog_addr ^ 16'h5A5A;
  // Data write from the logic unit lands one edge after its strobe
  always_ff @(posedge clk) begin
    if (we) begin
      dmem[data_addr] <= wdata;
    end
  end
endmodule // dcd_mem_model

// ===== dcd_core_bench.sv
// Purpose: Self-checking bench for the core datapath.
// Assumes: Strobes act one cycle; results show on the registered outputs next cycle.
// Notes: Inputs change by non-blocking assignment at the rising edge, or at the falling edge between tasks.
`timescale 1ns/1ps
module dcd_core_bench import dcd_pkg::*;;
  logic clk = 0, reset = 1, alu_en = 0, shift_use_reg = 0, acc_to_buf = 0, buf_to_acc = 0, plu_en = 0;
  logic plu_use_mask = 0, mpy_en = 0, multiplicand_load = 0, shift_count_load = 0, bit_pointer_load = 0;
  logic mask_load = 0, count_load_shift = 0, count_load_bit = 0, count_from_reg = 0, sign_extend_mode_flag = 0;
  logic overflow_saturate_mode = 0, dual_ram_space_select = 0, single_ram_overlay_bit = 0, decode = 0;
  logic prefetch = 0, pfc_load = 0, block_repeat_start = 0, page_load = 0, dir_access = 0, circ_load = 0;
  logic [15:0] data_in = 0, imm_in = 0, prog_in, aux_index_in = 0, aux_compare_in = 0, mode_in = 0;
  logic [15:0] branch_addr = 0, pfc_addr = 0, block_start_in = 0, block_end_in = 0, block_count_in = 0;
  logic [15:0] circ_start_one_in = 0, circ_end_one_in = 0, circ_start_two_in = 0, circ_end_two_in = 0;
  logic [4:0] shift_imm = 0;
  logic [2:0] post_shift = 0;
  logic [3:0] count_imm = 0;
  logic [8:0] page_in = 0;
  logic [6:0] dir_offset = 0;
  logic [7:0] global_region_reg = 0, circ_ctrl_in = 0;
  dcd_alu_op_t alu_op = DCD_ALU_NOP;
  dcd_src_t alu_src = DCD_SRC_DATA;
  dcd_msrc_t mpy_src = DCD_MSRC_NONE;
  dcd_plu_op_t plu_op = DCD_PLU_PASS;
  dcd_seq_t seq_op = DCD_SEQ_STEP;
  logic [31:0] acc_r, accumulator_buffer_r, product_reg_r;
  logic [15:0] acc_high_store_r, acc_low_store_r, multiplicand_reg_r, dynamic_shift_count_reg_r;
  logic [15:0] dynamic_bit_pointer_reg_r, bit_manip_mask_reg_r, plu_wdata_r, pc_r, prefetch_counter_r;
  logic [15:0] block_repeat_counter_r, block_start_addr_reg_r, block_end_addr_reg_r, data_addr_r;
  logic [15:0] circ_start_one_r, circ_end_one_r, circ_start_two_r, circ_end_two_r;
  logic [15:0] aux_index_reg_r, aux_compare_reg_r, processor_mode_reg_r;
  logic [3:0] prescale_count_r, stack_level_r;
  logic [8:0] data_page_pointer_r;
  logic [7:0] circ_buffer_control_r;
  logic plu_we_r, carry_r, overflow_flag_r, block_repeat_active_flag_r, global_bus_request_r;
  logic dual_ram_space_select_r, single_ram_overlay_bit_r;
  int fails = 0;
  int check_count = 0;

  dcd_core dut (.*);
  dcd_mem_model mem (.clk(clk), .data_addr(data_addr_r), .we(plu_we_r), .wdata(plu_wdata_r),
    .prog_addr(prefetch_counter_r), .prog_rdata(prog_in));

  // Clock of 10 ns period
  always #5 clk = ~clk;

  // Compare one value and report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  // Close the strobes of the current operation and settle its result
  task automatic fire;
    @(posedge clk);
    alu_en <= 0; acc_to_buf <= 0; buf_to_acc <= 0; plu_en <= 0; mpy_en <= 0;
    multiplicand_load <= 0; decode <= 0; pfc_load <= 0; page_load <= 0;
    shift_count_load <= 0; count_load_shift <= 0; shift_use_reg <= 0; block_repeat_start <= 0;
    @(negedge clk);
  endtask

  // One arithmetic unit operation on a shifted data word
  task automatic alu(input dcd_alu_op_t op, input logic [15:0] din, input logic [4:0] sh);
    @(posedge clk);
    alu_en <= 1; alu_op <= op; data_in <= din; shift_imm <= sh;
    fire;
  endtask

  // One multiply with the second operand from the chosen source
  task automatic mpy(input dcd_msrc_t src);
    @(posedge clk);
    mpy_en <= 1; mpy_src <= src;
    fire;
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    chk(pc_r, PC_RESET, "pc after reset");
    chk(circ_buffer_control_r, CBC_RESET, "circular control after reset");
    sign_extend_mode_flag <= 1;
    alu(DCD_ALU_LOAD, 16'h8001, 5'h04);
    chk(acc_r, 32'hFFF80010, "sign extended shift");
    sign_extend_mode_flag <= 0;
    alu(DCD_ALU_LOAD, 16'h8001, 5'h04);
    chk(acc_r, 32'h00080010, "zero filled shift");
    alu(DCD_ALU_LOAD, 16'hFFFF, 5'h10);
    chk(acc_r, 32'hFFFF0000, "shift by sixteen");
    @(posedge clk); acc_to_buf <= 1; fire;
    chk(accumulator_buffer_r, 32'hFFFF0000, "buffer copy");
    alu(DCD_ALU_LOAD, 16'h7FFF, 5'h10);
    overflow_saturate_mode <= 1;
    alu(DCD_ALU_ADD, 16'h7FFF, 5'h10);
    chk(acc_r, ACC_MAX, "positive saturation");
    chk(overflow_flag_r, 1'b1, "overflow flag");
    @(posedge clk); buf_to_acc <= 1; fire;
    chk(acc_r, 32'hFFFF0000, "buffer restore");
    @(posedge clk); page_load <= 1; page_in <= 9'h1A5; fire;
    @(posedge clk); dir_access <= 1; dir_offset <= 7'h3C; fire;
    chk(data_addr_r, 16'hD2BC, "direct address");
    @(posedge clk); plu_en <= 1; plu_op <= DCD_PLU_OR; data_in <= 16'h00F0; imm_in <= 16'h0F0F; fire;
    chk({plu_we_r, plu_wdata_r}, 17'h10FFF, "logic unit write");
    chk(acc_r, 32'hFFFF0000, "accumulator kept by logic unit");
    @(negedge clk);
    chk(mem.dmem[16'hD2BC], 16'h0FFF, "memory written");
    @(posedge clk); multiplicand_load <= 1; data_in <= 16'hFFFE; fire;
    chk(multiplicand_reg_r, 16'hFFFE, "multiplicand");
    imm_in <= 16'h0003;
    mpy(DCD_MSRC_IMM);
    chk(product_reg_r, 32'hFFFFFFFA, "immediate product");
    data_in <= 16'h0005;
    mpy(DCD_MSRC_DATA);
    chk(product_reg_r, 32'hFFFFFFF6, "data product");
    @(posedge clk); pfc_load <= 1; pfc_addr <= 16'h0040; fire;
    chk(prefetch_counter_r, 16'h0040, "prefetch load");
    mpy(DCD_MSRC_PROG);
    chk(product_reg_r, 32'hFFFF4BCC, "program product");
    alu_src <= DCD_SRC_PROD;
    alu(DCD_ALU_ADD, 16'h0000, 5'h00);
    chk(acc_r, 32'hFFFE4BCC, "product added");
    chk(carry_r, 1'b1, "carry out");
    post_shift <= 3'h1;
    alu_src <= DCD_SRC_DATA;
    fire;
    chk({acc_high_store_r, acc_low_store_r}, 32'hFFFC9798, "output shift words");
    alu(DCD_ALU_XOR, 16'h00FF, 5'h00);
    chk(acc_r, 32'hFFFE4B33, "boolean xor");
    @(posedge clk); shift_count_load <= 1; data_in <= 16'h0024; fire;
    shift_use_reg <= 1;
    count_load_shift <= 1;
    count_from_reg <= 1;
    alu(DCD_ALU_SHR, 16'h0000, 5'h00);
    chk(acc_r, 32'hFFFFFFFE, "clamped right shift");
    chk(prescale_count_r, 4'h4, "prescale from shift count");
    global_region_reg <= 8'h80;
    dual_ram_space_select <= 1;
    single_ram_overlay_bit <= 1;
    fire;
    chk({global_bus_request_r, dual_ram_space_select_r, single_ram_overlay_bit_r}, 3'h7, "global and map bits");
    @(posedge clk); block_repeat_start <= 1; block_start_in <= 16'h0002; block_end_in <= 16'h0003;
    block_count_in <= 16'h0001; fire;
    chk({block_start_addr_reg_r, block_end_addr_reg_r}, 32'h00020003, "block addresses");
    repeat (8) begin
      @(posedge clk); decode <= 1; fire;
    end
    chk(pc_r, 16'h0004, "block repeat jumps");
    chk({block_repeat_active_flag_r, block_repeat_counter_r}, 17'h0, "block repeat ends");
    @(posedge clk); decode <= 1; seq_op <= DCD_SEQ_INT; branch_addr <= 16'h0200; fire;
    alu(DCD_ALU_LOAD, 16'h1234, 5'h00);
    @(posedge clk); decode <= 1; seq_op <= DCD_SEQ_RET; fire;
    chk(acc_r, 32'hFFFFFFFE, "context restored");
    chk(pc_r, 16'h0005, "interrupt return address");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk); decode <= 1; seq_op <= DCD_SEQ_CALL; branch_addr <= 16'h0100 + 16'(i); fire;
    end
    chk(stack_level_r, 4'h8, "stack full refuses push");
    chk(pc_r, 16'h0108, "call target");
    @(posedge clk); decode <= 1; seq_op <= DCD_SEQ_RET; fire;
    chk(stack_level_r, 4'h7, "stack pop");
    tally_and_finish;
  end
endmodule // dcd_core_bench
